// *** dv/service_record_framer_bench.sv ***
/* bench for srf_framer: apb master, byte queue model, srf_peer far side.
   assumes one second shortened to SC cycles. */
`timescale 1ns/1ps
module service_record_framer_bench
    import srf_pkg::*;
;
    localparam int SC = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic linkBroken = 1'b0;
    logic [31:0] prdata, rd, rxU;
    logic pready, pslverr, er, txValid, txLast, txReady, rxValid, rxFirst;
    logic [7:0] txData, rxData, fl;
    logic reconnReq, deliveryFail;
    logic [7:0] exq[$];
    int failures = 0, checked = 0, cyc = 0, expSeq = 0, n;

    srf_framer #(.SEC_CYCLES(SC)) srf_framer_inst (.*);
    srf_peer peer (.*);

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic put(input logic [31:0] v, input int nb);
        for (int i = 0; i < nb; i++) exq.push_back(v[8*i+:8]);
    endtask
    task automatic waitFor(input bit rec, output int k);
        k = 0;
        while ((rec ? reconnReq : deliveryFail) !== 1'b1 && k < 300) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic sendRec(input logic [7:0] f, input logic ru, input int np);
        logic [31:0] un, inc, tm, sv;
        un = $urandom();
        inc = $urandom();
        tm = $urandom();
        sv = $urandom();
        exq = {};
        apb(1'b1, OFF_CTRL, {29'h0, 1'b1, ru, 1'b0});
        apb(1'b1, OFF_FLAGS, {24'h0, f});
        apb(1'b1, OFF_SVC, sv);
        apb(1'b1, OFF_UNIT, un);
        apb(1'b1, OFF_INCIDENT, inc);
        apb(1'b1, OFF_TIME, tm);
        put(np, 2);
        put(expSeq, 2);
        put(f, 1);
        if (f[FLG_UNIT]) put(ru ? rxU : un, 4);
        if (f[FLG_INCIDENT]) put(inc, 4);
        if (f[FLG_TIME]) put(tm, 4);
        put(sv, 1);
        put(sv[15:8], 1);
        repeat (np) begin
            un = $urandom();
            apb(1'b1, OFF_PAYLOAD, {24'h0, un[7:0]});
            put(un[7:0], 1);
        end
        peer.got = {};
        peer.recs = 0;
        apb(1'b1, OFF_CTRL, {30'h0, ru, 1'b1});
    endtask
    task automatic ckRec(input int k);
        while (peer.recs < k) @(posedge clk);
        chk(peer.got.size(), k * exq.size());
        foreach (peer.got[i]) chk(peer.got[i], exq[i % exq.size()]);
    endtask
    task automatic drain;
        while (peer.rq.size() != 0) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task automatic ackIt;
        peer.cmdRec(8'h00, 16'(expSeq), 8'h40, 32'h0);
        drain();
        apb(1'b0, OFF_STATUS, 32'h0);
        expSeq++;
        chk({rd[1], rd[31:16]}, {1'b1, 16'(expSeq)});
        apb(1'b1, OFF_STATUS, 32'h2);
    endtask

    initial begin
        forever #50 clk = ~clk;
    end
    // limit well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        void'($urandom(22));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, OFF_TIMING, 32'h0);
        chk(rd, 32'h001E0305);
        apb(1'b0, 8'h34, 32'h0);
        chk(er, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            fl = {5'($urandom()), 3'(i)};
            sendRec(fl, 1'b0, (i == 7) ? 16 : 1 + $urandom_range(14));
            ckRec(1);
            ackIt();
        end
        $display("record test done");
        apb(1'b1, OFF_TIMING, 32'h00020101);
        sendRec(8'h24, 1'b0, 3);
        ckRec(2);
        waitFor(1'b0, n);
        chk(n < 300, 1'b1);
        repeat (SC * 3) @(posedge clk);
        chk(peer.recs, 2);
        apb(1'b0, OFF_STATUS, 32'h0);
        expSeq++;
        chk({rd[2], rd[31:16]}, {1'b1, 16'(expSeq)});
        $display("retry test done");
        apb(1'b1, OFF_TIMING, 32'h00020305);
        rxU = $urandom();
        peer.cmdRec(8'h05, 16'h1234, 8'h41, rxU);
        drain();
        apb(1'b0, OFF_RXUNIT, 32'h0);
        chk(rd, rxU);
        apb(1'b0, OFF_RXHDR, 32'h0);
        chk(rd, {8'(peer.pSeq), 8'h41, 16'(peer.pSeq - 16'h1)});
        sendRec(8'h81, 1'b1, 2);
        ckRec(1);
        ackIt();
        $display("reply test done");
        linkBroken <= 1'b1;
        waitFor(1'b1, n);
        chk(n > SC && n < 300, 1'b1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[3], 1'b1);
        $display("link test done");
        final_report();
    end
endmodule

// *** dv/srf_asserts.sv ***
/* port checker for srf_framer.
   assumes a bind into every srf_framer instance. */
`timescale 1ns/1ps
module srf_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // stream and events
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    input wire logic txReady,
    input wire logic reconnReq,
    input wire logic deliveryFail
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rdy; psel && $rose(penable) |=> pready ##1 !pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_err; pready |-> pslverr == (paddr > 8'h30 || paddr[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("pslverr wrong");
    property p_wr0; pready && pwrite |-> prdata == 32'h0; endproperty
    a_wr0: assert property (p_wr0) else $error("prdata on write");
    property p_hold; txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast); endproperty
    a_hold: assert property (p_hold) else $error("byte not held");
    property p_gap; txValid && txReady && txLast |=> !txValid [*3]; endproperty
    a_gap: assert property (p_gap) else $error("no ack wait");
    property p_lastv; txLast |-> txValid; endproperty
    a_lastv: assert property (p_lastv) else $error("stray last");
    property p_fail; deliveryFail |-> !txValid ##1 !deliveryFail; endproperty
    a_fail: assert property (p_fail) else $error("fail pulse");
    property p_reco; reconnReq |-> !txValid ##1 !reconnReq; endproperty
    a_reco: assert property (p_reco) else $error("reconnect pulse");
endmodule

bind srf_framer srf_asserts chk_i (.*);

// *** dv/srf_peer.sv ***
/* far side model: sinks record bytes with random stalls, sends records.
   assumes the framer's clock. */
`timescale 1ns/1ps
module srf_peer (
    // clock
    input wire logic clk,
    // bytes from framer
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    output logic txReady = 1'b0,
    // bytes to framer
    output logic rxValid = 1'b0,
    output logic rxFirst = 1'b0,
    output logic [7:0] rxData = 8'h00
);
    logic [7:0] got[$];
    logic [8:0] rq[$];
    logic [15:0] pSeq = 16'h0;
    int recs = 0;
    always @(posedge clk) begin
        if (txValid && txReady) begin
            got.push_back(txData);
            recs += txLast;
        end
        txReady <= ($urandom_range(3) != 0);
        if (rq.size() > 0) begin
            {rxFirst, rxData} <= rq.pop_front();
            rxValid <= 1'b1;
        end else begin
            rxValid <= 1'b0;
            rxFirst <= 1'b0;
            rxData <= ~rxData; // idle line inverts the previous byte every cycle
        end
    end
    // one record, one sub-record of five bytes
    task automatic cmdRec(input logic [7:0] kind, input logic [15:0] w,
                          input logic [7:0] fl, input logic [31:0] un);
        logic [7:0] b[$];
        b = {8'h05, 8'h00, pSeq[7:0], pSeq[15:8], fl};
        if (fl[0]) b = {b, un[7:0], un[15:8], un[23:16], un[31:24]};
        b = {b, 8'h04, 8'h04, kind, 8'h02, 8'h00, w[7:0], w[15:8]};
        pSeq++;
        foreach (b[i]) rq.push_back({i == 0, b[i]});
    endtask
endmodule

// *** src/srf_framer.sv ***
/*
 * Service record framer: builds one record from APB-written header fields
 * and payload bytes, sends it as a byte stream, waits for its
 * acknowledgement with timeout and retry, parses incoming records and
 * their sub-records. Assumes the byte streams and linkBroken come from
 * logic on the same clock; multi-byte fields travel low byte first.
 */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// - sender waits ack_wait_seconds, default 5, for acknowledgement of each packet
// - unacknowledged packet is resent up to retry_limit times, default 3
// - after a link break, wait reconnect_wait_seconds, default 30, then reconnect
// - service payload is one or more records back to back
// - a record is a header then one or more sub-records
// - payload_size is two bytes giving the payload_body length only
// - sequence_count counts records 0 to 65535, wraps, keys acknowledgements
// - origin_on_vehicle is 1 when origin service is on the vehicle_terminal
// - dest_on_vehicle is 1 when destination service is on the vehicle_terminal
// - handling_priority runs 0 highest to 7 lowest
// - timestamp_present selects the 4-byte creation_seconds; parser skips it otherwise
// - incident_present selects the 4-byte incident_tag field
// - unit_id_present selects the 4-byte unit_ident field
// - order: size, sequence, flags, unit, incident, time, origin, dest, body
// - reply to a platform command carries the unit_ident received in it
// - creation_seconds counts seconds since midnight UTC 01.01.2010
// - same object and instant in one packet may carry time once
// - records of one event repeat the same incident_tag until all delivered
// - acknowledgement sub-records carry the acknowledged sequence_count
// - sub-record is kind byte, two-byte subentry_size, then that many bytes
// - subentry_kind 0 is reserved for acknowledgement sub-records
module srf_framer
    import srf_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DFLT
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // record bytes out
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txReady,
    // record bytes in
    input wire logic rxValid,
    input wire logic rxFirst,
    input wire logic [7:0] rxData,
    // link events
    input wire logic linkBroken,
    output logic reconnReq,
    output logic deliveryFail
);

    srf_state_t s;
    srf_state_t next_s;

    // header field order with optional fields skipped
    function automatic srf_field_t nextField(srf_field_t f, logic [7:0] fl);
        srf_field_t r;
        r = F_IDLE;
        case (f)
            F_SIZE: r = F_SEQ;
            F_SEQ: r = F_FLAGS;
            F_FLAGS: r = fl[FLG_UNIT] ? F_UNIT : fl[FLG_INCIDENT] ? F_INC :
                         fl[FLG_TIME] ? F_TIME : F_SST;
            F_UNIT: r = fl[FLG_INCIDENT] ? F_INC : fl[FLG_TIME] ? F_TIME : F_SST;
            F_INC: r = fl[FLG_TIME] ? F_TIME : F_SST;
            F_TIME: r = F_SST;
            F_SST: r = F_DST;
            F_DST: r = F_BODY;
            F_BODY: r = F_WAIT;
            default: r = F_IDLE;
        endcase
        return r;
    endfunction

    // index of the last byte of a header field
    function automatic logic [1:0] fieldLast(srf_field_t f);
        logic [1:0] r;
        r = 2'h0;
        case (f)
            F_SIZE, F_SEQ: r = 2'h1;
            F_UNIT, F_INC, F_TIME: r = 2'h3;
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    logic prep;
    logic acc;
    logic busy;
    logic tick;
    logic free;
    logic txEnd;
    logic [7:0] txByte;
    logic [15:0] paySize;
    srf_field_t rxCur;
    logic [1:0] rxI;
    logic [7:0] rxFl;
    logic subEnd;
    logic [15:0] fullSub;

    always_comb begin
        next_s = s;
        next_s.ackHit = 1'b0;
        next_s.reconnReq = 1'b0;
        next_s.failPulse = 1'b0;
        next_s.linkPrev = linkBroken;
        busy = s.txField != F_IDLE;
        paySize = 16'(s.payCnt);
        tick = s.secCnt == 32'(SEC_CYCLES - 1);
        next_s.secCnt = tick ? 32'h0 : s.secCnt + 32'h1;

        // one wait state: answer prepared in the first access cycle
        prep = psel & penable & ~s.pready;
        acc = psel & penable & s.pready;
        next_s.pready = prep;
        if (prep) begin
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h0;
            case (paddr)
                OFF_CTRL: next_s.prdata = {30'h0, s.useRxUnit, 1'b0};
                OFF_FLAGS: next_s.prdata = {24'h0, s.flags};
                OFF_SVC: next_s.prdata = {16'h0, s.dst, s.origin_service_kind};
                OFF_UNIT: next_s.prdata = s.unit;
                OFF_INCIDENT: next_s.prdata = s.incident;
                OFF_TIME: next_s.prdata = s.seconds;
                OFF_TIMING: next_s.prdata = {8'h0, s.reconn, s.retry, s.ackWait};
                OFF_PAYLOAD: next_s.prdata = {27'h0, s.payCnt};
                OFF_STATUS: next_s.prdata = {s.seq, s.attempts, 3'h0, s.stRxErr,
                    s.stReconn, s.stFail, s.stAckOk, busy};
                OFF_RXHDR: next_s.prdata = {s.rxRecCnt, s.rxFlags, s.rxSeq};
                OFF_RXUNIT: next_s.prdata = s.rxUnit;
                OFF_RXACK: next_s.prdata = {16'h0, s.rxAckSeq};
                OFF_RXSVC: next_s.prdata = {8'h0, s.rxSubCnt, s.rxDst, s.rxSst};
                default: next_s.pslverr = 1'b1;
            endcase
            // writes answer with zero data so no register leaks onto the bus
            if (pwrite) next_s.prdata = 32'h0;
        end

        // header fields are frozen while a record is in flight
        if (acc && pwrite) begin
            case (paddr)
                OFF_CTRL: begin
                    next_s.useRxUnit = pwdata[CTRL_USE_RX_UNIT];
                    if (!busy && pwdata[CTRL_CLR_PAYLOAD]) begin
                        next_s.payCnt = '0;
                    end
                    // an empty body would break the one-sub-record minimum
                    if (!busy && pwdata[CTRL_START] && s.payCnt != '0) begin
                        next_s.txField = F_SIZE;
                        next_s.txIdx = '0;
                        next_s.attempts = 8'h0;
                        next_s.curSeq = s.seq;
                        next_s.txUnit = s.useRxUnit ? s.rxUnit : s.unit;
                    end
                end
                OFF_FLAGS: if (!busy) next_s.flags = pwdata[7:0];
                OFF_SVC: if (!busy) begin
                    next_s.origin_service_kind = pwdata[7:0];
                    next_s.dst = pwdata[15:8];
                end
                OFF_UNIT: if (!busy) next_s.unit = pwdata;
                OFF_INCIDENT: if (!busy) next_s.incident = pwdata;
                OFF_TIME: if (!busy) next_s.seconds = pwdata;
                OFF_TIMING: begin
                    next_s.ackWait = pwdata[7:0];
                    next_s.retry = pwdata[15:8];
                    next_s.reconn = pwdata[23:16];
                end
                OFF_PAYLOAD: if (!busy && s.payCnt != PAY_CNT_W'(PAY_DEPTH)) begin
                    next_s.pay[s.payCnt[PAY_IDX_W-1:0]] = pwdata[7:0];
                    next_s.payCnt = s.payCnt + 1'b1;
                end
                OFF_STATUS: begin
                    // write one to clear; a set in the same cycle wins below
                    if (pwdata[1]) next_s.stAckOk = 1'b0;
                    if (pwdata[2]) next_s.stFail = 1'b0;
                    if (pwdata[3]) next_s.stReconn = 1'b0;
                    if (pwdata[4]) next_s.stRxErr = 1'b0;
                end
                default: ;
            endcase
        end

        // byte for the current sender position
        txByte = 8'h0;
        case (s.txField)
            F_SIZE: txByte = s.txIdx[0] ? paySize[15:8] : paySize[7:0];
            F_SEQ: txByte = s.txIdx[0] ? s.curSeq[15:8] : s.curSeq[7:0];
            F_FLAGS: txByte = s.flags;
            F_UNIT: txByte = s.txUnit[{s.txIdx[1:0], 3'h0} +: 8];
            F_INC: txByte = s.incident[{s.txIdx[1:0], 3'h0} +: 8];
            F_TIME: txByte = s.seconds[{s.txIdx[1:0], 3'h0} +: 8];
            F_SST: txByte = s.origin_service_kind;
            F_DST: txByte = s.dst;
            F_BODY: txByte = s.pay[s.txIdx[PAY_IDX_W-1:0]];
            default: txByte = 8'h0;
        endcase

        // sender
        free = ~s.txValid | txReady;
        txEnd = s.txField == F_BODY ? s.txIdx == s.payCnt - 1'b1 :
            s.txIdx[1:0] == fieldLast(s.txField);
        unique case (s.txField)
            F_IDLE: ;
            F_WAIT: begin
                // acknowledgement matched on sequence_count only
                if (s.ackHit && s.rxAckSeq == s.curSeq) begin
                    next_s.stAckOk = 1'b1;
                    next_s.txField = F_IDLE;
                    next_s.seq = s.curSeq + 16'h1;
                end else if (tick) begin
                    if ({1'b0, s.waitSec} + 9'h1 >= {1'b0, s.ackWait}) begin
                        if (s.attempts < s.retry) begin
                            next_s.attempts = s.attempts + 8'h1;
                            next_s.txField = F_SIZE;
                            next_s.txIdx = '0;
                        end else begin
                            next_s.stFail = 1'b1;
                            next_s.failPulse = 1'b1;
                            next_s.txField = F_IDLE;
                            next_s.seq = s.curSeq + 16'h1;
                        end
                    end else begin
                        next_s.waitSec = s.waitSec + 8'h1;
                    end
                end
            end
            F_RECONN: begin
                if (tick) begin
                    if ({1'b0, s.waitSec} + 9'h1 >= {1'b0, s.reconn}) begin
                        next_s.reconnReq = 1'b1;
                        next_s.stReconn = 1'b1;
                        next_s.txField = F_IDLE;
                    end else begin
                        next_s.waitSec = s.waitSec + 8'h1;
                    end
                end
            end
            default: begin
                if (free) begin
                    next_s.txValid = 1'b1;
                    next_s.txData = txByte;
                    next_s.txLast = s.txField == F_BODY && txEnd;
                    if (txEnd) begin
                        next_s.txIdx = '0;
                        next_s.txField = nextField(s.txField, s.flags);
                        if (s.txField == F_BODY) begin
                            next_s.secCnt = 32'h0;
                            next_s.waitSec = 8'h0;
                        end
                    end else begin
                        next_s.txIdx = s.txIdx + 1'b1;
                    end
                end
            end
        endcase
        if (s.txValid && txReady && (s.txField == F_WAIT || s.txField == F_IDLE)) begin
            next_s.txValid = 1'b0;
            next_s.txLast = 1'b0;
        end
        // a broken link aborts the record in flight; sequence_count is kept
        if (linkBroken && !s.linkPrev) begin
            next_s.txField = F_RECONN;
            next_s.txValid = 1'b0;
            next_s.txLast = 1'b0;
            next_s.secCnt = 32'h0;
            next_s.waitSec = 8'h0;
        end

        // receiver
        rxCur = rxFirst ? F_SIZE : s.rxField;
        rxI = rxFirst ? 2'h0 : s.rxIdx;
        rxFl = rxCur == F_FLAGS ? rxData : s.rxFlags;
        subEnd = 1'b0;
        fullSub = {rxData, s.subLeft[15:8]};
        if (rxValid) begin
            next_s.rxField = rxCur;
            next_s.rxIdx = rxI;
            case (rxCur)
                F_SIZE: next_s.rxSize = {rxData, s.rxSize[15:8]};
                F_SEQ: next_s.rxSeq = {rxData, s.rxSeq[15:8]};
                F_FLAGS: next_s.rxFlags = rxData;
                F_UNIT: next_s.rxUnit = {rxData, s.rxUnit[31:8]};
                F_SST: next_s.rxSst = rxData;
                F_DST: next_s.rxDst = rxData;
                default: ; // incident and time bytes are skipped
            endcase
            if (rxCur == F_BODY) begin
                next_s.rxBody = s.rxBody + 16'h1;
                unique case (s.subSt)
                    SUB_KIND: begin
                        next_s.subKind = rxData;
                        next_s.subSt = SUB_SIZE;
                        next_s.subIdx = 2'h0;
                    end
                    SUB_SIZE: begin
                        next_s.subLeft = fullSub;
                        if (s.subIdx == 2'h0) begin
                            next_s.subIdx = 2'h1;
                        end else if (fullSub == 16'h0) begin
                            subEnd = 1'b1;
                        end else begin
                            next_s.subSt = SUB_DATA;
                            next_s.subIdx = 2'h0;
                        end
                    end
                    SUB_DATA: begin
                        if (s.subIdx == 2'h0) next_s.ackTmp[7:0] = rxData;
                        if (s.subIdx == 2'h1) next_s.ackTmp[15:8] = rxData;
                        if (s.subIdx != 2'h2) next_s.subIdx = s.subIdx + 2'h1;
                        next_s.subLeft = s.subLeft - 16'h1;
                        subEnd = s.subLeft == 16'h1;
                    end
                endcase
                if (subEnd) begin
                    next_s.subSt = SUB_KIND;
                    next_s.rxSubCnt = s.rxSubCnt + 8'h1;
                    // kind 0 means acknowledgement in every service
                    if (s.subKind == ACK_KIND && s.subSt == SUB_DATA && s.subIdx != 2'h0) begin
                        next_s.ackHit = 1'b1;
                        next_s.rxAckSeq = next_s.ackTmp;
                    end
                end
                if (s.rxBody + 16'h1 == s.rxSize) begin
                    next_s.rxField = F_SIZE;
                    next_s.rxIdx = 2'h0;
                    next_s.rxRecCnt = s.rxRecCnt + 8'h1;
                    if (!subEnd) next_s.stRxErr = 1'b1;
                end
            end else if (rxI == fieldLast(rxCur)) begin
                next_s.rxIdx = 2'h0;
                next_s.rxField = nextField(rxCur, rxFl);
                if (rxCur == F_DST) begin
                    next_s.rxBody = 16'h0;
                    next_s.subSt = SUB_KIND;
                    // a record must hold at least one sub-record
                    if (s.rxSize == 16'h0) begin
                        next_s.stRxErr = 1'b1;
                        next_s.rxField = F_SIZE;
                    end
                end
            end else begin
                next_s.rxIdx = rxI + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.ackWait <= ACK_WAIT_RST;
            s.retry <= RETRY_RST;
            s.reconn <= RECONN_RST;
            s.rxField <= F_SIZE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign txValid = s.txValid;
    assign txData = s.txData;
    assign txLast = s.txLast;
    assign reconnReq = s.reconnReq;
    assign deliveryFail = s.failPulse;

endmodule

// *** src/srf_pkg.sv ***
/*
 * Shared constants and types of the service record framer: register byte
 * offsets, field layout of header_flags, reset values, timing counts and
 * the packed state record. Assumes a 10 MHz system clock.
 */
package srf_pkg;

    // register byte offsets on the APB slave
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_SVC = 8'h08;
    localparam logic [7:0] OFF_UNIT = 8'h0C;
    localparam logic [7:0] OFF_INCIDENT = 8'h10;
    localparam logic [7:0] OFF_TIME = 8'h14;
    localparam logic [7:0] OFF_TIMING = 8'h18;
    localparam logic [7:0] OFF_PAYLOAD = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_RXHDR = 8'h24;
    localparam logic [7:0] OFF_RXUNIT = 8'h28;
    localparam logic [7:0] OFF_RXACK = 8'h2C;
    localparam logic [7:0] OFF_RXSVC = 8'h30;

    // control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_USE_RX_UNIT = 1;
    localparam int CTRL_CLR_PAYLOAD = 2;

    // header_flags layout
    localparam int FLG_ORIGIN = 7;
    localparam int FLG_DEST = 6;
    localparam int FLG_PRIO_LSB = 3;
    localparam int FLG_TIME = 2;
    localparam int FLG_INCIDENT = 1;
    localparam int FLG_UNIT = 0;

    // transport parameter reset values
    localparam logic [7:0] ACK_WAIT_RST = 8'h05;
    localparam logic [7:0] RETRY_RST = 8'h03;
    localparam logic [7:0] RECONN_RST = 8'h1E;

    // subentry_kind reserved for acknowledgements
    localparam logic [7:0] ACK_KIND = 8'h00;

    // one second in clock cycles
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SEC_CYCLES_DFLT = SECOND_NS / CLK_PERIOD_NS;

    // payload buffer
    localparam int PAY_DEPTH = 16;
    localparam int PAY_IDX_W = 4;
    localparam int PAY_CNT_W = 5;

    typedef enum logic [3:0] {
        F_IDLE, F_SIZE, F_SEQ, F_FLAGS, F_UNIT, F_INC, F_TIME, F_SST, F_DST,
        F_BODY, F_WAIT, F_RECONN
    } srf_field_t;

    typedef enum logic [1:0] {SUB_KIND, SUB_SIZE, SUB_DATA} srf_sub_t;

    typedef struct packed {
        // bus answer
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        // configuration
        logic useRxUnit;
        logic [7:0] flags;
        logic [7:0] origin_service_kind;
        logic [7:0] dst;
        logic [31:0] unit;
        logic [31:0] incident;
        logic [31:0] seconds;
        logic [7:0] ackWait;
        logic [7:0] retry;
        logic [7:0] reconn;
        logic [PAY_DEPTH-1:0][7:0] pay;
        logic [PAY_CNT_W-1:0] payCnt;
        // sender
        srf_field_t txField;
        logic [PAY_CNT_W-1:0] txIdx;
        logic txValid;
        logic [7:0] txData;
        logic txLast;
        logic [15:0] seq;
        logic [15:0] curSeq;
        logic [31:0] txUnit;
        logic [7:0] attempts;
        logic [31:0] secCnt;
        logic [7:0] waitSec;
        logic linkPrev;
        logic reconnReq;
        logic failPulse;
        // sticky status
        logic stAckOk;
        logic stFail;
        logic stReconn;
        logic stRxErr;
        // receiver
        srf_field_t rxField;
        logic [1:0] rxIdx;
        logic [15:0] rxSize;
        logic [15:0] rxBody;
        logic [15:0] rxSeq;
        logic [7:0] rxFlags;
        logic [31:0] rxUnit;
        logic [7:0] rxSst;
        logic [7:0] rxDst;
        srf_sub_t subSt;
        logic [1:0] subIdx;
        logic [15:0] subLeft;
        logic [7:0] subKind;
        logic [15:0] ackTmp;
        logic [15:0] rxAckSeq;
        logic ackHit;
        logic [7:0] rxSubCnt;
        logic [7:0] rxRecCnt;
    } srf_state_t;

endpackage
